// *** octal_irq_pkg.sv ***
// Shared constants and types for the eight-channel interrupt vectoring block
package octal_irq_pkg;
   // Bus geometry
   localparam int ADDR_W = 9;
   localparam int DATA_W = 8;
   localparam int CHAN_NUM = 8;
   localparam int CHAN_W = 3;
   localparam int SRC_W = 16;
   localparam int SYNC_STAGES = 3;
   // Low address bits inside each channel window; bits 8:6 carry the channel
   localparam logic [5:0] GLOBAL_REG_OFFSET = 6'h38;
   localparam logic [5:0] STATUS_LOW_OFFSET = 6'h3a;
   localparam logic [5:0] STATUS_HIGH_OFFSET = 6'h3b;
   localparam int CHAN_ADDR_LSB = 6;
   // Reset values
   localparam logic [7:0] GLOBAL_STATUS_RESET = 8'h00;
   localparam logic [7:0] VECTOR_BASE_RESET = 8'h00;
   localparam logic [2:0] RESET_TOP_CHANNEL = 3'h0;
   // Vector base fields: 7:6 top bits, 5 bit-five source, 4:2 extension, 1 cyclic, 0 extension select
   localparam int VB_TOP_LSB = 6;
   localparam int VB_B5_BIT = 5;
   localparam int VB_EXT_LSB = 2;
   localparam int VB_ROT_BIT = 1;
   localparam int VB_EDA_BIT = 0;
   // Global status fields: 7:4 ports A..D, 3 any channel, 2:0 winning channel
   localparam int GS_PORT_LSB = 4;
   localparam int GS_CII_BIT = 3;

   typedef struct packed {
      logic rd_n;
      logic wr_n;
      logic interrupt_acknowledge_n_n;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] data;
   } bus_pins_s;

   typedef struct packed {
      logic [3:0] ports;
      logic any_channel_pending;
      logic [CHAN_W-1:0] chan;
   } global_status_s;

   typedef struct packed {
      logic [1:0] top;
      logic b5;
      logic [2:0] ext;
      logic cyclic_priority_enable;
      logic eda;
   } vector_base_s;
endpackage

// *** octal_irq_vectoring.sv ***
// Global interrupt status, channel priority and vector generation for eight serial channels
// Operation
// RL1 - Four port bits in the global status mirror pending port interrupts regardless of channel state.
// RL2 - The any-channel bit is set whenever any unmasked channel source is active.
// RL3 - While that bit is set the three-bit field names the channel holding the top-priority active source.
// RL4 - Global status freezes during and after acknowledge, at the first read after a vector, at status reads.
// RL5 - The global status reads identically at all eight channel addresses 038h to 1F8h.
// RL6 - A vector base write makes the channel given by its address (38h->0 ... 1F8h->7) the top-priority channel; code: VERSION2 builds only.
// RL7 - The new top channel takes effect at the end of the write strobe and holds until the next such write; code: full rotation moves it after service.
// RL8 - During acknowledge the vector is driven on D7..D0 with bits 7:6 from the top programmed bits.
// RL9 - In the second version bit 5 comes from the programmed bit only in extended mode; in the first always.
// RL10 - In extended mode vector bits 4:2 equal the three programmed extension bits.
// RL11 - Extended mode puts the programmed extension in bits 5:2 (4:2 first version), otherwise the channel number.
// RL12 - With cyclic priority off the channel order never changes after service.
// RL13 - With cyclic priority on, order is readjusted after each service over 8 channels, or 7 with one fixed.
// RL14 - Software must write the cyclic bit as zero on a first-version device.
// RL15 - In full rotation the serviced channel becomes the lowest priority.
// RL16 - Masked sources add nothing to global status, vector or interrupt output.
// RL17 - After reset channel 0 is top priority and priority falls with rising channel number.
`timescale 1ns/1ps
module octal_irq_vectoring
   import octal_irq_pkg::*;
#(
   parameter logic VERSION2 = 1'b1
) (
   input wire logic i_clk_sys,
   input wire logic i_rst_n,
   input wire logic i_rd_n,
   input wire logic i_wr_n,
   input wire logic i_interrupt_acknowledge_n_n,
   input wire logic [ADDR_W-1:0] i_addr,
   input wire logic [DATA_W-1:0] i_data,
   input wire logic [3:0] i_port_pending,
   input wire logic [CHAN_NUM-1:0][SRC_W-1:0] i_chan_status,
   input wire logic [CHAN_NUM-1:0][SRC_W-1:0] i_chan_mask,
   input wire logic i_seven_cycle_select,
   output logic [DATA_W-1:0] o_data,
   output logic o_data_oe_n,
   output logic o_int_n,
   output logic o_serviced,
   output logic [CHAN_W-1:0] o_serviced_channel,
   output logic [CHAN_W-1:0] o_top_channel
);

   // First active channel scanning upward from start, optionally skipping one channel
   function automatic logic [CHAN_W:0] pick(input logic [CHAN_NUM-1:0] act, input logic [CHAN_W-1:0] start,
                                            input logic use_skip, input logic [CHAN_W-1:0] skip);
      logic [CHAN_W:0] res;
      logic [CHAN_W-1:0] ch;
      res = '0;
      for (int i = CHAN_NUM - 1; i >= 0; i--) begin
         ch = start + CHAN_W'(i);
         if (act[ch] && !(use_skip && ch == skip)) begin
            res = {1'b1, ch};
         end
      end
      return res;
   endfunction

   // Vector byte for a given channel and programmed base
   function automatic logic [DATA_W-1:0] build_vector(input vector_base_s vb, input logic [CHAN_W-1:0] ch);
      logic [3:0] mid;
      if (vb.eda) begin
         mid = {vb.b5, vb.ext}; // [RL10] [RL11]
      end else begin
         mid = {VERSION2 ? 1'b0 : vb.b5, ch}; // [RL9] [RL11]
      end
      return {vb.top, mid, 2'b00}; // [RL8]
   endfunction

   bus_pins_s sync_r [SYNC_STAGES];
   bus_pins_s filt_r, filt_nxt, agree;
   logic [2:0] prev_r;

   // Pin synchroniser: a bit changes once the second and third stages agree
   always_comb begin
      agree = ~(sync_r[1] ^ sync_r[2]);
      filt_nxt = (agree & sync_r[2]) | (~agree & filt_r);
   end

   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         for (int i = 0; i < SYNC_STAGES; i++) begin
            sync_r[i] <= '{rd_n: 1'b1, wr_n: 1'b1, interrupt_acknowledge_n_n: 1'b1, addr: '0, data: '0};
         end
         filt_r <= '{rd_n: 1'b1, wr_n: 1'b1, interrupt_acknowledge_n_n: 1'b1, addr: '0, data: '0};
         prev_r <= 3'h7;
      end else begin
         sync_r[0] <= '{rd_n: i_rd_n, wr_n: i_wr_n, interrupt_acknowledge_n_n: i_interrupt_acknowledge_n_n, addr: i_addr, data: i_data};
         for (int i = 1; i < SYNC_STAGES; i++) begin
            sync_r[i] <= sync_r[i-1];
         end
         filt_r <= filt_nxt;
         prev_r <= {filt_r.rd_n, filt_r.wr_n, filt_r.interrupt_acknowledge_n_n};
      end
   end

   // Strobe levels and edges
   logic rd_act, wr_end, interrupt_acknowledge_n_act, interrupt_acknowledge_n_start, interrupt_acknowledge_n_end, rd_start;
   logic hit_global, hit_status;
   assign rd_act = !filt_r.rd_n;
   assign rd_start = !filt_r.rd_n && prev_r[2];
   assign wr_end = filt_r.wr_n && !prev_r[1];
   assign interrupt_acknowledge_n_act = !filt_r.interrupt_acknowledge_n_n;
   assign interrupt_acknowledge_n_start = !filt_r.interrupt_acknowledge_n_n && prev_r[0];
   assign interrupt_acknowledge_n_end = filt_r.interrupt_acknowledge_n_n && !prev_r[0];
   assign hit_global = filt_r.addr[5:0] == GLOBAL_REG_OFFSET; // [RL5]
   assign hit_status = filt_r.addr[5:0] == STATUS_LOW_OFFSET || filt_r.addr[5:0] == STATUS_HIGH_OFFSET;

   // Per-channel pending after masking
   logic [CHAN_NUM-1:0] act;
   for (genvar c = 0; c < CHAN_NUM; c++) begin : g_act
      assign act[c] = |(i_chan_status[c] & ~i_chan_mask[c]); // [RL16]
   end

   // Priority state: full-rotation start, fixed channel and seven-channel start
   vector_base_s vb_r, vb_nxt;
   logic [CHAN_W-1:0] hp_r, hp_nxt, fix_r, fix_nxt, rb_r, rb_nxt;
   global_status_s gis_r, gis_nxt, live;
   logic frz_r, frz_nxt, release_frz;
   logic seven, rotating;
   logic [CHAN_W:0] win;

   assign rotating = VERSION2 && vb_r.cyclic_priority_enable;
   assign seven = rotating && i_seven_cycle_select;

   // Arbitration over active channels
   always_comb begin
      if (seven) begin
         win = act[fix_r] ? {1'b1, fix_r} : pick(act, rb_r, 1'b1, fix_r); // [RL13]
      end else begin
         win = pick(act, hp_r, 1'b0, fix_r); // [RL3] [RL17]
      end
      live.ports = i_port_pending; // [RL1]
      live.any_channel_pending = |act; // [RL2]
      live.chan = win[CHAN_W-1:0];
   end

   // Register writes and priority readjustment after service
   always_comb begin
      vb_nxt = vb_r;
      hp_nxt = hp_r;
      fix_nxt = fix_r;
      rb_nxt = rb_r;
      if (wr_end && hit_global) begin
         vb_nxt = vector_base_s'(filt_r.data);
         if (VERSION2) begin
            hp_nxt = filt_r.addr[CHAN_ADDR_LSB +: CHAN_W]; // [RL6] [RL7]
            fix_nxt = filt_r.addr[CHAN_ADDR_LSB +: CHAN_W];
            rb_nxt = filt_r.addr[CHAN_ADDR_LSB +: CHAN_W] + 3'h1;
         end
      end else if (interrupt_acknowledge_n_end && gis_r.any_channel_pending && rotating) begin // [RL12]
         if (seven) begin
            if (gis_r.chan != fix_r) begin
               rb_nxt = gis_r.chan + 3'h1; // [RL13]
            end
         end else begin
            hp_nxt = gis_r.chan + 3'h1; // [RL15]
         end
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         vb_r <= vector_base_s'(VECTOR_BASE_RESET);
         hp_r <= RESET_TOP_CHANNEL; // [RL17]
         fix_r <= RESET_TOP_CHANNEL;
         rb_r <= RESET_TOP_CHANNEL + 3'h1;
      end else begin
         vb_r <= vb_nxt;
         hp_r <= hp_nxt;
         fix_r <= fix_nxt;
         rb_r <= rb_nxt;
      end
   end

   // Global status freeze: held until the frozen winner is cleared and no read or acknowledge runs
   always_comb begin
      release_frz = frz_r && !interrupt_acknowledge_n_act && !rd_act && !(gis_r.any_channel_pending && act[gis_r.chan]);
      frz_nxt = frz_r;
      if (interrupt_acknowledge_n_start || (rd_start && (hit_global || hit_status))) begin
         frz_nxt = 1'b1; // [RL4]
      end else if (release_frz) begin
         frz_nxt = 1'b0;
      end
      gis_nxt = (frz_r && !release_frz) ? gis_r : live; // [RL4]
   end

   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         frz_r <= 1'b0;
         gis_r <= global_status_s'(GLOBAL_STATUS_RESET);
      end else begin
         frz_r <= frz_nxt;
         gis_r <= gis_nxt;
      end
   end

   // Data bus drive, interrupt output and service report
   logic [DATA_W-1:0] data_nxt;
   logic oe_n_nxt, int_n_nxt, svc_nxt;
   logic [CHAN_W-1:0] top_nxt;
   always_comb begin
      data_nxt = '0;
      oe_n_nxt = 1'b1;
      int_n_nxt = !live.any_channel_pending; // [RL16]
      svc_nxt = interrupt_acknowledge_n_end && gis_r.any_channel_pending;
      top_nxt = seven ? fix_r : hp_r;
      if (interrupt_acknowledge_n_act && gis_r.any_channel_pending) begin
         data_nxt = build_vector(vb_r, gis_r.chan); // [RL8]
         oe_n_nxt = 1'b0;
      end else if (rd_act && hit_global) begin
         data_nxt = gis_r; // [RL5]
         oe_n_nxt = 1'b0;
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_data <= '0;
         o_data_oe_n <= 1'b1;
         o_int_n <= 1'b1;
         o_serviced <= 1'b0;
         o_serviced_channel <= '0;
         o_top_channel <= RESET_TOP_CHANNEL;
      end else begin
         o_data <= data_nxt;
         o_data_oe_n <= oe_n_nxt;
         o_int_n <= int_n_nxt;
         o_serviced <= svc_nxt;
         o_serviced_channel <= gis_r.chan;
         o_top_channel <= top_nxt;
      end
   end

   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (!i_rst_n);

   property p_int_follows; (|act) |=> !o_int_n; endproperty
   a_int_follows: assert property (p_int_follows) else $error("interrupt output missed active source"); // [RL2]
   property p_masked_quiet; (act == '0) |=> o_int_n; endproperty
   a_masked_quiet: assert property (p_masked_quiet) else $error("interrupt output with only masked sources"); // [RL16]
   property p_ports_track; !frz_r |=> gis_r.ports == $past(i_port_pending); endproperty
   a_ports_track: assert property (p_ports_track) else $error("port bits do not track port pending"); // [RL1]
   // The reported channel must have been one of the active channels
   property p_winner_active;
      (!frz_r && |act) |=> gis_r.any_channel_pending && ((($past(act) >> gis_r.chan) & 8'h01) != 8'h00);
   endproperty
   a_winner_active: assert property (p_winner_active) else $error("channel flag not set"); // [RL3]
   property p_frozen; (frz_r && !release_frz) |=> $stable(gis_r); endproperty
   a_frozen: assert property (p_frozen) else $error("global status changed while frozen"); // [RL4]
   property p_read_any; (rd_act && hit_global && !interrupt_acknowledge_n_act) |=> (o_data == $past(gis_r)) && !o_data_oe_n; endproperty
   a_read_any: assert property (p_read_any) else $error("global status read mismatch"); // [RL5]
   property p_top_write; (VERSION2 && wr_end && hit_global) |=> hp_r == $past(filt_r.addr[8:6]); endproperty
   a_top_write: assert property (p_top_write) else $error("top channel not taken from address"); // [RL6]
   property p_fix_hold; !(wr_end && hit_global) |=> $stable(fix_r); endproperty
   a_fix_hold: assert property (p_fix_hold) else $error("top channel moved without write"); // [RL7]
   property p_vec_top; (interrupt_acknowledge_n_act && gis_r.any_channel_pending) |=> o_data[7:6] == $past(vb_r.top) && !o_data_oe_n; endproperty
   a_vec_top: assert property (p_vec_top) else $error("vector top bits wrong"); // [RL8]
   property p_vec_ext; (interrupt_acknowledge_n_act && gis_r.any_channel_pending && vb_r.eda) |=> o_data[5:2] == $past({vb_r.b5, vb_r.ext}); endproperty
   a_vec_ext: assert property (p_vec_ext) else $error("vector extension bits wrong"); // [RL10]
   property p_fixed_order; (!vb_r.cyclic_priority_enable && !(wr_end && hit_global)) |=> $stable(hp_r); endproperty
   a_fixed_order: assert property (p_fixed_order) else $error("fixed priority order changed"); // [RL12]
   property p_rot_full; (interrupt_acknowledge_n_end && gis_r.any_channel_pending && rotating && !seven && !(wr_end && hit_global))
      |=> hp_r == $past(gis_r.chan) + 3'h1; endproperty
   a_rot_full: assert property (p_rot_full) else $error("serviced channel not moved to lowest"); // [RL15]
   c_vector: cover property (interrupt_acknowledge_n_act && gis_r.any_channel_pending ##1 !o_data_oe_n);
   c_rotate: cover property (interrupt_acknowledge_n_end && gis_r.any_channel_pending && rotating);
   c_seven: cover property (interrupt_acknowledge_n_end && seven && gis_r.chan != fix_r);
   c_write_top: cover property (wr_end && hit_global && filt_r.addr[8:6] == 3'h7);

endmodule // octal_irq_vectoring

// *** cpu_model.sv ***
// Microprocessor bus model issuing read, write and acknowledge cycles
`timescale 1ns/1ps
module cpu_model
   import octal_irq_pkg::*;
#(
   parameter logic VERSION2 = 1'b1
) (
   input wire logic i_clk_sys,
   input wire logic [DATA_W-1:0] i_data,
   input wire logic i_data_oe_n,
   output bus_pins_s o_bus
);
   // Idle bus with every strobe released
   initial begin
      o_bus = '{rd_n: 1'b1, wr_n: 1'b1, interrupt_acknowledge_n_n: 1'b1, addr: '0, data: 8'h5a};
   end

   // Read cycle: strobe held well past the pin filter, data taken before release
   task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
      @(negedge i_clk_sys);
      o_bus.addr = a;
      o_bus.rd_n = 1'b0;
      repeat (8) @(negedge i_clk_sys);
      d = i_data;
      o_bus.rd_n = 1'b1;
      repeat (8) @(negedge i_clk_sys);
   endtask

   // Write cycle: address and data stay put around the closing strobe edge
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      @(negedge i_clk_sys);
      o_bus.addr = a;
      o_bus.data = VERSION2 ? d : (d & 8'hfd); // Cyclic bit kept zero on a first-version part
      o_bus.wr_n = 1'b0;
      repeat (8) @(negedge i_clk_sys);
      o_bus.wr_n = 1'b1;
      repeat (6) @(negedge i_clk_sys);
      o_bus.data = ~o_bus.data; // Released data lines no longer show the written value
      repeat (4) @(negedge i_clk_sys);
   endtask

   // Acknowledge cycle: vector and drive state taken while the strobe is low
   task automatic ack(output logic [DATA_W-1:0] v, output logic drv);
      @(negedge i_clk_sys);
      o_bus.interrupt_acknowledge_n_n = 1'b0;
      repeat (8) @(negedge i_clk_sys);
      v = i_data;
      drv = ~i_data_oe_n;
      o_bus.interrupt_acknowledge_n_n = 1'b1;
      repeat (8) @(negedge i_clk_sys);
   endtask
endmodule // cpu_model

// *** tb.sv ***
// Self-checking bench for the interrupt vectoring block
`timescale 1ns/1ps
module tb
   import octal_irq_pkg::*;
;
   logic clk_sys, rst_n, data_oe_n, int_n, serviced, svc_seen, drv, seven_sel;
   logic [3:0] port_pending;
   logic [CHAN_NUM-1:0][SRC_W-1:0] chan_status, chan_mask;
   logic [DATA_W-1:0] data, rd_data, vec;
   logic [CHAN_W-1:0] serviced_channel, top_channel, svc_ch;
   bus_pins_s bus;
   int n_errors = 0;
   int checks = 0;
   int cycles = 0;

   octal_irq_vectoring #(.VERSION2(1'b1)) u_octal_irq_vectoring (
      .i_clk_sys(clk_sys), .i_rst_n(rst_n), .i_rd_n(bus.rd_n), .i_wr_n(bus.wr_n),
      .i_interrupt_acknowledge_n_n(bus.interrupt_acknowledge_n_n), .i_addr(bus.addr), .i_data(bus.data), .i_port_pending(port_pending),
      .i_chan_status(chan_status), .i_chan_mask(chan_mask), .i_seven_cycle_select(seven_sel),
      .o_data(data), .o_data_oe_n(data_oe_n), .o_int_n(int_n), .o_serviced(serviced),
      .o_serviced_channel(serviced_channel), .o_top_channel(top_channel)
   );
   cpu_model #(.VERSION2(1'b1)) u_cpu_model (
      .i_clk_sys(clk_sys), .i_data(data), .i_data_oe_n(data_oe_n), .o_bus(bus)
   );

   // Clock at 25 MHz
   initial begin
      clk_sys = 1'b0;
      forever #20 clk_sys = ~clk_sys;
   end

   // Hang guard and service pulse catcher
   always @(posedge clk_sys) begin
      cycles <= cycles + 1;
      if (serviced === 1'b1) begin
         svc_seen <= 1'b1;
         svc_ch <= serviced_channel;
      end
      if (cycles == 4000) begin
         n_errors = n_errors + 1;
         test_done();
      end
   end

   task automatic test_done();
      if (n_errors == 0 && checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
      checks++;
      if (got !== exp) begin
         $display("BAD %s expected %h seen %h", name, exp, got);
         n_errors++;
      end
   endtask

   task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [7:0] exp);
      u_cpu_model.rd(a, rd_data);
      chk("global status", exp, rd_data);
   endtask

   // Acknowledge, then vector, drive and service pulse compared; no drive and no pulse without a pending channel
   task automatic ack_chk(input logic pend, input logic [7:0] exp, input logic [2:0] ch);
      svc_seen = 1'b0;
      u_cpu_model.ack(vec, drv);
      chk("vector", exp, vec);
      chk("vector drive", {7'h0, pend}, {7'h0, drv});
      chk("serviced", {7'h0, pend}, {7'h0, svc_seen});
      if (pend) begin
         chk("serviced channel", {5'h0, ch}, {5'h0, svc_ch});
      end
   endtask

   // Main sequence
   initial begin
      rst_n = 1'b0;
      port_pending = 4'h0;
      chan_status = '0;
      chan_mask = '0;
      svc_seen = 1'b0;
      svc_ch = 3'h0;
      seven_sel = 1'b0;
      repeat (5) @(negedge clk_sys);
      rst_n = 1'b1;
      repeat (2) @(negedge clk_sys);
      chk("int idle", 8'h01, {7'h0, int_n});
      rd_chk(9'h038, 8'h00);
      port_pending = 4'ha;
      for (int c = 0; c < CHAN_NUM; c++) begin
         rd_chk({c[2:0], GLOBAL_REG_OFFSET}, 8'ha0);
      end
      port_pending = 4'h0;
      chan_status[5][0] = 1'b1;
      chan_mask[5][0] = 1'b1;
      repeat (3) @(negedge clk_sys);
      chk("int masked", 8'h01, {7'h0, int_n});
      rd_chk(9'h178, 8'h00);
      chan_mask[5][0] = 1'b0;
      chan_status[2][8] = 1'b1;
      repeat (3) @(negedge clk_sys);
      chk("int active", 8'h00, {7'h0, int_n});
      rd_chk(9'h0b8, 8'h0a);
      chan_status[1][3] = 1'b1;
      rd_chk(9'h038, 8'h0a);
      chan_status[1][3] = 1'b0;
      u_cpu_model.wr(9'h178, 8'hac);
      chk("top channel", 8'h05, {5'h0, top_channel});
      ack_chk(1'b1, 8'h88, 3'h2);
      chk("top fixed", 8'h05, {5'h0, top_channel});
      chan_status[2][8] = 1'b0;
      repeat (3) @(negedge clk_sys);
      rd_chk(9'h1f8, 8'h0d);
      chan_status[5][0] = 1'b0;
      u_cpu_model.wr(9'h038, 8'h7b);
      chan_status[3][15] = 1'b1;
      repeat (3) @(negedge clk_sys);
      ack_chk(1'b1, 8'h78, 3'h3);
      chk("top rotated", 8'h04, {5'h0, top_channel});
      seven_sel = 1'b1;
      chan_status[3][15] = 1'b0;
      u_cpu_model.wr(9'h0f8, 8'h02);
      chk("top seven", 8'h03, {5'h0, top_channel});
      chan_status[1][0] = 1'b1;
      chan_status[6][0] = 1'b1;
      repeat (3) @(negedge clk_sys);
      ack_chk(1'b1, 8'h18, 3'h6);
      chan_status[6][0] = 1'b0;
      repeat (3) @(negedge clk_sys);
      rd_chk(9'h038, 8'h09);
      chan_status[1][0] = 1'b0;
      chan_status[3][0] = 1'b1;
      chan_status[7][0] = 1'b1;
      repeat (3) @(negedge clk_sys);
      rd_chk(9'h0b8, 8'h0b);
      rd_chk(9'h0fa, 8'h00);
      chan_status = '0;
      repeat (3) @(negedge clk_sys);
      ack_chk(1'b0, 8'h00, 3'h0);
      test_done();
   end
endmodule // tb
